// >>> pkg/pwm_gen_pkg.sv
// Shared constants and types for the motor PWM generator control block.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
package pwm_gen_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;  // generator_control
    localparam logic [11:0] PIN_OFF  = 12'h004;  // generator_pin_control
    localparam logic [11:0] KEY_OFF  = 12'h008;  // unlock_key_register
    localparam logic [11:0] ACK_OFF  = 12'h00C;  // controller pending acknowledge
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // generator_control fields
    // ------------------------------------------------------------
    localparam int FLAG_LSB   = 27;  // flags at 31..27
    localparam int EN_LSB     = 19;  // enables at 23..19
    localparam int FLTSTAT_B  = 15;
    localparam int CLSTAT_B   = 14;
    localparam int ITB_B      = 9;
    localparam int DTC_LSB    = 6;
    localparam int COMP_POLARITY_SELECT_B     = 5;
    localparam int DIR_B      = 4;
    localparam int MASTER_BASE_SELECT_B     = 3;
    localparam int EXTERNAL_RESET_CONTROL_B    = 1;
    localparam int NFLAGS     = 5;
    localparam logic [31:0] CTRL_CFG_MASK = 32'h000002EA;  // INDEPENDENT_BASE_SELECT, DEAD_TIME_CONTROL_FIELD, COMP_POLARITY_SELECT, MASTER_BASE_SELECT, EXTERNAL_RESET_CONTROL
    localparam logic [1:0]  DTC_COMP      = 2'h3;

    // ------------------------------------------------------------
    // generator_pin_control fields
    // ------------------------------------------------------------
    localparam int LIMIT_SOURCE_SELECT_LSB  = 23;
    localparam int FAULT_SOURCE_SELECT_LSB = 19;
    localparam int FAULT_MODE_SELECT_B   = 18;
    localparam int CURRENT_LIMIT_MODE_B    = 17;
    localparam int HIGH_PIN_OWNERSHIP_B     = 15;
    localparam int LOW_PIN_OWNERSHIP_B     = 14;
    localparam int HIGH_SIDE_POLARITY_B     = 13;
    localparam int POLL_B     = 12;
    localparam int FDATH_B    = 3;
    localparam int FDATL_B    = 2;
    localparam logic [31:0] PIN_MASK  = 32'h07FEF00C;
    localparam logic [31:0] PIN_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Unlock key and timing
    // ------------------------------------------------------------
    localparam logic [15:0] KEY_FIRST  = 16'hABCD;
    localparam logic [15:0] KEY_SECOND = 16'h4321;
    localparam logic [1:0]  XP_LAG     = 2'h2;  // PWM ticks after deassertion
    localparam int NSRC = 16;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } key_state_t;

    typedef struct packed {
        logic fault;
        logic limit;
        logic trig;
        logic zero;
        logic period;
    } flags_t;
endpackage

// >>> design/pwm_gen_ctrl.sv
// Per-generator control, event flags, fault routing and unlock logic for one motor PWM generator.
// Assumes time-base ticks, duty, period, trigger and mode inputs come from logic on pclk;
// fault, comparator, compensation and lock-fuse inputs come from outside and are synchronised.
//
// What this block does
// - Fault flag bit 31 sets on fault event, holds until software clears.
// - Current-limit flag bit 30 sets on a current-limit event.
// - Trigger flag bit 29 sets when the timer matches the trigger compare.
// - Timer-zero flag bit 28 sets when the timer reaches zero.
// - Period-match flag bit 27 sets when the timer matches period.
// - Fault enable bit 23 with fault flag raises interrupt event.
// - Current-limit enable bit 22 with its flag raises interrupt event.
// - Controller pending stays high while any local flag is set.
// - Compensation polarity only acts when dead-time control field is 11.
// - Polarity bit 5 picks which output shortens for each sense level.
// - Bit 4 reads one while timer decrements, zero while incrementing.
// - Bit 3 selects secondary master time base, else primary.
// - External reset bit 1, with independent base bit 9 set and limit mode off, lets current limit reset timer in deassertion.
// - Limit during assertion resets timer two ticks after deassertion.
// - Negative dead time only applies in edge-aligned operation.
// - Generator always clocks from a master time base tick.
// - Fault source field 22-19 selects pins, comparators or pin fifteen.
// - Locked pin-control write needs key pair as the previous accesses.
// - Fault drives outputs from fault data through polarity settings.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pwm_gen_ctrl
    import pwm_gen_pkg::*;
(
    input  wire logic              pclk,             // APB clock, 250 MHz
    input  wire logic              presetn,          // Async reset, active low
    input  wire logic [ADDR_W-1:0] paddr,            // APB address
    input  wire logic              psel,             // APB select
    input  wire logic              penable,          // APB enable
    input  wire logic              pwrite,           // APB direction
    input  wire logic [31:0]       pwdata,           // APB write data
    output logic      [31:0]       prdata,           // APB read data
    output logic                   pready,           // APB ready
    output logic                   pslverr,          // APB error on unmapped address
    input  wire logic              primary_tick,     // Primary master time base enable
    input  wire logic              secondary_tick,   // Secondary master time base enable
    input  wire logic              module_enable,    // Module running
    input  wire logic              center_mode,      // Center-aligned counting
    input  wire logic [15:0]       period_value,     // Timer period
    input  wire logic [15:0]       duty_value,       // Duty compare
    input  wire logic [15:0]       trigger_value,    // Trigger compare
    input  wire logic [7:0]        dead_time,        // Signed dead time in ticks
    input  wire logic [7:0]        fault_input_pin,  // Fault pins one to eight
    input  wire logic              fault_pin15,      // Fault pin fifteen
    input  wire logic [4:0]        comparator_in,    // Comparator outputs one to five
    input  wire logic              comp_sense_input, // Dead-time compensation sense
    input  wire logic              write_lock_fuse,  // Zero means pin control is locked
    output logic                   high_side_output, // High-side pin level
    output logic                   high_side_oe,     // High-side pin owned by generator
    output logic                   low_side_output,  // Low-side pin level
    output logic                   low_side_oe,      // Low-side pin owned by generator
    output logic                   irq_event,        // Enabled local event pending
    output logic                   controller_pending_flag // Shared controller flag
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [NSRC+1:0] sync1_q;
    logic [NSRC+1:0] sync2_q;
    logic [NSRC-1:0] src;
    logic            sense_s;
    logic            fuse_s;

    // Two-stage capture of all asynchronous pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {write_lock_fuse, comp_sense_input, fault_pin15, 2'b00, comparator_in, fault_input_pin};
            sync2_q <= sync1_q;
        end
    end
    assign src     = sync2_q[NSRC-1:0];
    assign sense_s = sync2_q[NSRC];
    assign fuse_s  = sync2_q[NSRC+1];

    // Reserved codes map to tied-low source bits, so they never fault
    function automatic logic pick_source(input logic [3:0] code, input logic [NSRC-1:0] v);
        pick_source = v[code];
    endfunction

    // ------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] pin_q;
    logic [NFLAGS-1:0] flag_q;
    logic [NFLAGS-1:0] en_q;
    key_state_t  key_q;
    logic        acc;
    logic        wr_ctrl;
    logic        wr_pin;
    logic        wr_key;
    logic        wr_ack;
    logic        pin_open;
    logic        mapped;

    assign acc      = psel & penable & pready;
    assign wr_ctrl  = acc & pwrite & (paddr == CTRL_OFF);
    assign wr_pin   = acc & pwrite & (paddr == PIN_OFF);
    assign wr_key   = acc & pwrite & (paddr == KEY_OFF);
    assign wr_ack   = acc & pwrite & (paddr == ACK_OFF);
    assign mapped   = (paddr == CTRL_OFF) | (paddr == PIN_OFF) | (paddr == KEY_OFF) | (paddr == ACK_OFF);
    assign pin_open = fuse_s | (key_q == KEY_OPEN);

    // One wait state keeps pready and prdata straight from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // unlock sequence, any other access breaks it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q <= KEY_IDLE;
        end else if (acc) begin
            case (key_q)
                KEY_IDLE: key_q <= (wr_key && pwdata[15:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                KEY_HALF: key_q <= (wr_key && pwdata[15:0] == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                KEY_OPEN: key_q <= KEY_IDLE;
                default:  key_q <= KEY_IDLE;
            endcase
        end
    end

    // Configuration fields of generator_control and the enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
            en_q  <= '0;
        end else if (wr_ctrl) begin
            cfg_q <= pwdata & CTRL_CFG_MASK;
            en_q  <= pwdata[EN_LSB +: NFLAGS];
        end
    end

    // pin-control write dropped silently while locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= PIN_RESET;
        end else if (wr_pin && pin_open) begin
            pin_q <= pwdata & PIN_MASK;
        end
    end

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic        tick;
    logic [15:0] cnt_q;
    logic        dir_q;
    logic        high_phase;
    logic [1:0]  deassert_q;
    logic        xp_on;
    logic        xp_req_q;
    logic        xp_reset;
    logic        limit_lvl;
    logic        limit_lvl_q;

    // tick always from a master time base
    assign tick       = cfg_q[MASTER_BASE_SELECT_B] ? secondary_tick : primary_tick;
    assign high_phase = cnt_q < duty_value;
    assign limit_lvl  = pick_source(pin_q[LIMIT_SOURCE_SELECT_LSB +: 4], src);
    // reset only with independent base and limit mode off
    assign xp_on      = cfg_q[EXTERNAL_RESET_CONTROL_B] & cfg_q[ITB_B] & ~pin_q[CURRENT_LIMIT_MODE_B];
    assign xp_reset   = tick & xp_req_q & ~high_phase & (deassert_q == XP_LAG);

    // Counter, up only when edge-aligned, up/down when center-aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            dir_q <= 1'b0;
        end else if (!module_enable) begin
            cnt_q <= '0;
            dir_q <= 1'b0;
        end else if (xp_reset) begin
            cnt_q <= '0;
            dir_q <= 1'b0;
        end else if (tick) begin
            if (!center_mode) begin
                cnt_q <= (cnt_q >= period_value) ? 16'h0000 : cnt_q + 16'h0001;
                dir_q <= 1'b0;
            end else if (!dir_q) begin
                if (cnt_q >= period_value) begin
                    dir_q <= 1'b1;
                    cnt_q <= cnt_q - 16'h0001;
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end else if (cnt_q == 16'h0000) begin
                dir_q <= 1'b0;
                cnt_q <= 16'h0001;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deassert_q <= 2'h0;
        end else if (tick) begin
            if (high_phase) begin
                deassert_q <= 2'h0;
            end else if (deassert_q != XP_LAG) begin
                deassert_q <= deassert_q + 2'h1;
            end
        end
    end

    // latch a limit edge until the deferred reset happens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xp_req_q    <= 1'b0;
            limit_lvl_q <= 1'b0;
        end else begin
            limit_lvl_q <= limit_lvl;
            if (!xp_on) begin
                xp_req_q <= 1'b0;
            end else if (limit_lvl & ~limit_lvl_q) begin
                xp_req_q <= 1'b1;
            end else if (xp_reset) begin
                xp_req_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Events and local flags
    // ------------------------------------------------------------
    flags_t      set_evt;
    logic        fault_lvl;
    logic        fault_lvl_q;
    logic        fault_on;
    logic        limit_on;
    logic        any_enabled;

    assign fault_lvl       = pick_source(pin_q[FAULT_SOURCE_SELECT_LSB +: 4], src);
    assign fault_on        = pin_q[FAULT_MODE_SELECT_B] & fault_lvl;
    assign limit_on        = pin_q[CURRENT_LIMIT_MODE_B] & limit_lvl;
    assign set_evt.fault   = fault_on & ~(pin_q[FAULT_MODE_SELECT_B] & fault_lvl_q);
    assign set_evt.limit   = limit_on & ~(pin_q[CURRENT_LIMIT_MODE_B] & limit_lvl_q);
    assign set_evt.trig    = tick & module_enable & (cnt_q == trigger_value);
    assign set_evt.zero    = tick & module_enable & (cnt_q == 16'h0000);
    assign set_evt.period  = tick & module_enable & (cnt_q == period_value);
    assign any_enabled     = |(flag_q & en_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_lvl_q <= 1'b0;
        end else begin
            fault_lvl_q <= fault_lvl;
        end
    end

    // write zero clears, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            for (int i = 0; i < NFLAGS; i++) begin
                flag_q[i] <= set_evt[i] | (flag_q[i] & ~(wr_ctrl & ~pwdata[FLAG_LSB + i]));
            end
        end
    end

    // shared flag cannot clear while any local flag stands, enabled or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_pending_flag <= 1'b0;
            irq_event               <= 1'b0;
        end else begin
            irq_event <= any_enabled;
            if (any_enabled) begin
                controller_pending_flag <= 1'b1;
            end else if (wr_ack && pwdata[0] && !(|flag_q)) begin
                controller_pending_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Output shaping
    // ------------------------------------------------------------
    logic signed [17:0] dt_eff;
    logic signed [17:0] h_end;
    logic signed [17:0] l_start;
    logic signed [17:0] cnt_s;
    logic               comp_on;
    logic               lengthen_high;
    logic               h_act;
    logic               l_act;

    // negative dead time only when edge-aligned
    assign dt_eff  = (center_mode && dead_time[7]) ? 18'sd0 : 18'(signed'(dead_time));
    assign cnt_s   = signed'({2'b00, cnt_q});
    // compensation only with field at 11
    assign comp_on = (cfg_q[DTC_LSB +: 2] == DTC_COMP);
    // polarity and sense pick the lengthened side
    assign lengthen_high = cfg_q[COMP_POLARITY_SELECT_B] ? ~sense_s : sense_s;

    always_comb begin
        h_end   = signed'({2'b00, duty_value});
        l_start = h_end + dt_eff;
        if (comp_on) begin
            h_end   = lengthen_high ? h_end + dt_eff : h_end - dt_eff;
            l_start = h_end;
        end
        h_act = module_enable & (cnt_s < h_end);
        l_act = module_enable & (cnt_s >= l_start);
    end

    // fault data overrides, mapped through polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_output <= 1'b0;
            low_side_output  <= 1'b0;
            high_side_oe     <= 1'b0;
            low_side_oe      <= 1'b0;
        end else begin
            high_side_oe     <= pin_q[HIGH_PIN_OWNERSHIP_B];
            low_side_oe      <= pin_q[LOW_PIN_OWNERSHIP_B];
            high_side_output <= (fault_on ? pin_q[FDATH_B] : h_act) ^ pin_q[HIGH_SIDE_POLARITY_B];
            low_side_output  <= (fault_on ? pin_q[FDATL_B] : l_act) ^ pin_q[POLL_B];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] ctrl_rd;

    always_comb begin
        ctrl_rd = cfg_q;
        ctrl_rd[FLAG_LSB +: NFLAGS] = flag_q;
        ctrl_rd[EN_LSB +: NFLAGS]   = en_q;
        ctrl_rd[FLTSTAT_B]          = fault_on;
        ctrl_rd[CLSTAT_B]           = limit_on;
        ctrl_rd[DIR_B]              = dir_q;
    end

    // Key reads as zero so the sequence cannot be observed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && penable && !pready && !pwrite) begin
            case (paddr)
                CTRL_OFF: prdata <= ctrl_rd;
                PIN_OFF:  prdata <= pin_q;
                ACK_OFF:  prdata <= {31'h00000000, controller_pending_flag};
                default:  prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_fault_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        set_evt.fault |=> flag_q[4]) else $error("fault flag not set");
    a_limit_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        set_evt.limit |=> ctrl_rd[30]) else $error("limit flag not set");
    a_zero_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && module_enable && cnt_q == 16'h0000) |=> ctrl_rd[28]) else $error("zero flag not set");
    a_period_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && module_enable && cnt_q == period_value) |=> ctrl_rd[27]) else $error("period flag not set");
    a_flag_w0_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && !pwdata[31] && !set_evt.fault) |=> !flag_q[4]) else $error("fault flag not cleared");
    a_pending_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_q[4] && en_q[4]) |=> controller_pending_flag && irq_event) else $error("pending dropped");
    a_lock_blocks_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_pin && !fuse_s && key_q != KEY_OPEN) |=> $stable(pin_q)) else $error("locked write taken");
    a_xp_waits_lag: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && high_phase && module_enable) |=> !xp_reset) else $error("reset during assertion");
    a_fault_drive: assert property (@(posedge pclk) disable iff (!presetn)
        fault_on |=> high_side_output == ($past(pin_q[FDATH_B]) ^ $past(pin_q[HIGH_SIDE_POLARITY_B])))
        else $error("fault drive wrong");
    a_dir_report: assert property (@(posedge pclk) disable iff (!presetn)
        (module_enable && center_mode && tick && !xp_reset && !dir_q && cnt_q >= period_value) |=> ctrl_rd[4])
        else $error("direction not reported");
endmodule

// >>> testbench/fault_sense_model.sv
// Far-side model: external fault pins, comparators and compensation sense.
// Assumes the bench names one source by a one-hot level vector.
`timescale 1ns/100ps
module fault_sense_model (
    input  wire logic [15:0] src_level,        // One bit per fault source code
    output logic      [7:0]  fault_input_pin,  // Fault pins one to eight
    output logic             fault_pin15,      // Fault pin fifteen
    output logic      [4:0]  comparator_in,    // Comparators one to five
    output logic             comp_sense_input  // Compensation sense, held low
);
    // Codes 13 and 14 have no wire, so those bits are dropped
    assign fault_input_pin  = src_level[7:0];
    assign comparator_in    = src_level[12:8];
    assign fault_pin15      = src_level[15];
    assign comp_sense_input = 1'b0;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the generator control block over APB.
// Assumes one wait state per access; the master still waits on pready.
`timescale 1ns/100ps
module tb_top;
    import pwm_gen_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fuse = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, hs, hs_oe, ls, ls_oe, irq, pend, err;
    logic [15:0] src = 16'h0;
    logic [7:0] flt;
    logic fp15, sense;
    logic ptk = 0, stk = 0, men = 0;
    logic [4:0] cmp;
    int fails = 0, n_checks = 0;
    always #2 pclk = ~pclk;
    fault_sense_model u_far (.src_level(src), .fault_input_pin(flt), .fault_pin15(fp15),
        .comparator_in(cmp), .comp_sense_input(sense));
    pwm_gen_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_tick(ptk), .secondary_tick(stk), .module_enable(men), .center_mode(1'b0),
        .period_value(16'h0010), .duty_value(16'h0008), .trigger_value(16'h0004), .dead_time(8'h00),
        .fault_input_pin(flt), .fault_pin15(fp15), .comparator_in(cmp), .comp_sense_input(sense),
        .write_lock_fuse(fuse), .high_side_output(hs), .high_side_oe(hs_oe), .low_side_output(ls),
        .low_side_oe(ls_oe), .irq_event(irq), .controller_pending_flag(pend));
    // One APB transfer; hold everything until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look at pready between edges, where it has settled, then pass the edge that takes it
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // One master time base pulse, primary or secondary
    task automatic tk(input logic s);
        @(posedge pclk);
        ptk <= ~s; stk <= s;
        @(posedge pclk);
        ptk <= 1'b0; stk <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset values and an unmapped address
    task automatic t_reset();
        apb(0, CTRL_OFF, 0); chk(rd, 32'h0);
        apb(0, PIN_OFF, 0); chk(rd, PIN_RESET);
        apb(0, 12'h010, 0); chk({rd[30:0], err}, 32'h1);
    endtask
    // Every fault source code, reserved codes must stay quiet
    // sources only change while the module is stopped
    task automatic t_sources();
        for (int c = 0; c < 16; c++) begin
            apb(1, PIN_OFF, (32'h1 << FAULT_MODE_SELECT_B) | (32'(c) << FAULT_SOURCE_SELECT_LSB));
            src <= 16'h1 << c;
            repeat (6) @(posedge pclk);
            apb(0, CTRL_OFF, 0);
            chk(rd[31], (c == 13 || c == 14) ? 1'b0 : 1'b1);
            src <= 16'h0;
            apb(1, CTRL_OFF, 0);
        end
    endtask
    // Enable raises the event; writing one keeps, zero clears
    task automatic t_irq();
        // fault data high active, low inverted by its polarity
        apb(1, PIN_OFF, (32'h1 << FAULT_MODE_SELECT_B) | 32'h0000_100C);
        src <= 16'h1;
        repeat (6) @(posedge pclk);
        chk(irq, 1'b0);
        chk({hs, ls}, 2'h2);
        apb(1, CTRL_OFF, 32'h8080_0000);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        chk(pend, 1'b1);
        apb(1, ACK_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        chk(pend, 1'b1);
        apb(0, CTRL_OFF, 0); chk(rd[31], 1'b1);
        apb(1, CTRL_OFF, 32'h0000_0000);
        apb(0, CTRL_OFF, 0); chk(rd[31], 1'b0);
        src <= 16'h0;
        apb(1, ACK_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        chk(pend, 1'b0);
    endtask
    // Timer flags, time base choice and the deferred external reset
    task automatic t_timer();
        men <= 1'b1;
        apb(1, PIN_OFF, 0);
        apb(1, CTRL_OFF, 0);
        repeat (2) tk(1);
        apb(0, CTRL_OFF, 0); chk(rd[31:27], 5'h00);
        repeat (17) tk(0);
        apb(0, CTRL_OFF, 0); chk(rd[31:27], 5'h07);
        apb(1, CTRL_OFF, 32'h0000_020A);
        tk(0);
        tk(1);
        apb(0, CTRL_OFF, 0); chk(rd[31:27], 5'h02);
        apb(1, CTRL_OFF, 32'h0000_020A);
        src <= 16'h1;
        repeat (10) tk(1);
        apb(0, CTRL_OFF, 0); chk(rd[31:27], 5'h04);
        tk(1);
        apb(0, CTRL_OFF, 0); chk(rd[31:27], 5'h06);
        src <= 16'h0;
        men <= 1'b0;
    endtask
    // Locked pin control: only key pair then the very next access works
    task automatic t_lock();
        apb(1, PIN_OFF, 0);
        fuse <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1, PIN_OFF, 32'h0000_C000);
        apb(0, PIN_OFF, 0); chk(rd, 32'h0);
        apb(1, KEY_OFF, 32'(KEY_FIRST)); apb(1, KEY_OFF, 32'(KEY_SECOND));
        apb(1, PIN_OFF, 32'h0000_C000);
        apb(0, PIN_OFF, 0); chk(rd, 32'h0000_C000);
        chk({hs_oe, ls_oe}, 2'h3);
        apb(1, KEY_OFF, 32'(KEY_FIRST)); apb(1, KEY_OFF, 32'(KEY_SECOND));
        apb(0, CTRL_OFF, 0);
        apb(1, PIN_OFF, 0);
        apb(0, PIN_OFF, 0); chk(rd, 32'h0000_C000);
    endtask
    // Watchdog sized well past the expected run
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sources();
        t_irq();
        t_timer();
        t_lock();
        print_verdict();
    end
endmodule
